/* File: src/core_working_regs.sv */
// Behaviour
// - 8-bit accumulator outside data memory; carries ALU operands and results.
// - interrupt entry saves nothing; accumulator and flags stay as left.
// - save copies accumulator and flags to hidden buffers; restore reloads both.
// - status bits 7:6 hold last reset cause: 00 wdt, 01 rsvd, 10 lvd, 11 pin.
// - carry bit 2 set on add carry, no borrow, rotate out one, compare >= 0.
// - nibble carry bit 1 set on low-nibble carry or subtraction without nibble borrow.
// - zero bit 0 set when add, subtract, logic or compare result is zero.
// - instruction pointer is 10 bits, 2 high and 8 low, cleared on reset.
// - instruction pointer increments by one after each instruction.
// - jump and call load the full 10-bit destination address.
// - seven skip instructions advance instruction pointer by 2 when true.
// - bit-test skip when tested bit equals zero or one per form.
// - compare-skip when accumulator equals immediate or memory operand.
// - increment-skip when operand wraps ff to 00; result to acc or memory.
// - decrement-skip when operand wraps 00 to ff; result to acc or memory.
// - add into low pointer byte with overflow increments the high byte.
// - subtract from low pointer byte never changes the high byte.
// - writing low pointer byte continues at current high byte plus written byte.
// - bank and index pointers serve as work registers, RAM and ROM pointers.
// - table read puts ROM word high byte in table register, low in accumulator.
// - add and subtract update zero, carry and nibble-carry flags; increment- and decrement-skip update no flags.
`timescale 1ns/1ns
`include "core_regs_cfg.svh"

module core_working_regs (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire core_regs_pkg::op_t op,
  input wire logic to_mem,
  input wire logic [7:0] operand,
  input wire logic [7:0] dest_addr,
  input wire logic [2:0] bit_sel,
  input wire logic [9:0] jump_target,
  input wire logic [15:0] rom_word,
  input wire logic [1:0] reset_cause_in,
  input wire logic [7:0] sreg_raddr,
  output logic [9:0] prog_addr,
  output logic [7:0] accumulator,
  output logic [7:0] bank_ptr,
  output logic [7:0] index_ptr,
  output logic [7:0] sreg_rdata,
  output logic mem_we,
  output logic [7:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic skip_taken
);
  import core_regs_pkg::*;

  logic [7:0] acc_q;
  logic [7:0] acc_save_q;
  logic [7:0] table_high_q;
  logic [7:0] index_q;
  logic [7:0] bank_q;
  logic [1:0] cause_q;
  logic [2:0] flags_q;
  logic [7:0] flags_save_q;
  logic [9:0] ip_q;
  logic [7:0] sreg_rdata_q;
  logic mem_we_q;
  logic [7:0] mem_addr_q;
  logic [7:0] mem_wdata_q;
  logic skip_q;

  logic [7:0] status_view;
  logic [7:0] arg_a;
  logic [7:0] arg_b;
  logic [8:0] wide;
  logic [4:0] nib;
  logic [7:0] res;
  logic wr_res;
  logic res_to_mem;
  logic [2:0] flags_d;
  logic skip_d;
  logic low_carry;
  logic [9:0] ip_d;
  logic [9:0] ip_inc;

  assign status_view = {cause_q, 3'b000, flags_q};
  // memory-form arithmetic works as M op A, accumulator form as A op M
  assign arg_a = to_mem ? operand : acc_q;
  assign arg_b = to_mem ? acc_q : operand;
  assign ip_inc = ip_q + `STEP_ONE;

  always_comb begin
    wide = 9'h000;
    nib = 5'h00;
    res = 8'h00;
    wr_res = 1'b0;
    res_to_mem = to_mem;
    flags_d = flags_q;
    skip_d = 1'b0;
    low_carry = 1'b0;
    case (op)
      OP_MOV: begin
        res = to_mem ? acc_q : operand;
        wr_res = 1'b1;
      end
      OP_MOVI: begin
        res = operand;
        wr_res = 1'b1;
        res_to_mem = 1'b1;
      end
      OP_ADD, OP_ADC: begin
        wide = {1'b0, arg_a} + {1'b0, arg_b} + {8'h00, op == OP_ADC && flags_q[`FLAG_CARRY]};
        nib = {1'b0, arg_a[3:0]} + {1'b0, arg_b[3:0]} + {4'h0, op == OP_ADC && flags_q[`FLAG_CARRY]};
        res = wide[7:0];
        wr_res = 1'b1;
        low_carry = wide[8];
        flags_d[`FLAG_CARRY] = wide[8];
        flags_d[`FLAG_NIBBLE] = nib[4];
        flags_d[`FLAG_ZERO] = wide[7:0] == 8'h00;
      end
      OP_SUB, OP_SBC: begin
        wide = {1'b0, arg_a} - {1'b0, arg_b} - {8'h00, op == OP_SBC && !flags_q[`FLAG_CARRY]};
        nib = {1'b0, arg_a[3:0]} - {1'b0, arg_b[3:0]} - {4'h0, op == OP_SBC && !flags_q[`FLAG_CARRY]};
        res = wide[7:0];
        wr_res = 1'b1;
        flags_d[`FLAG_CARRY] = !wide[8];
        flags_d[`FLAG_NIBBLE] = !nib[4];
        flags_d[`FLAG_ZERO] = wide[7:0] == 8'h00;
      end
      OP_AND, OP_OR, OP_XOR: begin
        if (op == OP_AND) begin
          res = acc_q & operand;
        end else if (op == OP_OR) begin
          res = acc_q | operand;
        end else begin
          res = acc_q ^ operand;
        end
        wr_res = 1'b1;
        flags_d[`FLAG_ZERO] = res == 8'h00;
      end
      OP_RLC: begin
        res = {operand[6:0], flags_q[`FLAG_CARRY]};
        wr_res = 1'b1;
        flags_d[`FLAG_CARRY] = operand[7];
      end
      OP_RRC: begin
        res = {flags_q[`FLAG_CARRY], operand[7:1]};
        wr_res = 1'b1;
        flags_d[`FLAG_CARRY] = operand[0];
      end
      OP_COMPARE_SKIP_EQ: begin
        wide = {1'b0, acc_q} - {1'b0, operand};
        flags_d[`FLAG_CARRY] = !wide[8];
        flags_d[`FLAG_ZERO] = wide[7:0] == 8'h00;
        skip_d = acc_q == operand;
      end
      OP_INC_SKIP_TO_ACCUM, OP_INC_SKIP_TO_MEM: begin
        res = operand + 8'h01;
        wr_res = 1'b1;
        res_to_mem = op == OP_INC_SKIP_TO_MEM;
        skip_d = operand == 8'hff;
      end
      OP_DEC_SKIP_TO_ACCUM, OP_DEC_SKIP_TO_MEM: begin
        res = operand - 8'h01;
        wr_res = 1'b1;
        res_to_mem = op == OP_DEC_SKIP_TO_MEM;
        skip_d = operand == 8'h00;
      end
      OP_BIT_TEST_SKIP_CLEAR: skip_d = !operand[bit_sel];
      OP_BIT_TEST_SKIP_SET: skip_d = operand[bit_sel];
      default: begin
        res = 8'h00;
      end
    endcase
  end

  // instruction pointer next value
  always_comb begin
    ip_d = ip_inc;
    if (op == OP_JMP || op == OP_CALL) begin
      ip_d = jump_target;
    end else if (skip_d) begin
      ip_d = ip_q + `SKIP_STEP;
    end else if (wr_res && res_to_mem && dest_addr == `ADDR_IP_LOW) begin
      ip_d = {ip_q[9:8] + {1'b0, low_carry && (op == OP_ADD || op == OP_ADC)}, res};
    end else if (wr_res && res_to_mem && dest_addr == `ADDR_IP_HIGH) begin
      // high write keeps the low step
      ip_d = {res[1:0], ip_inc[7:0]};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ip_q <= `IP_RESET;
    end else if (instr_valid) begin
      ip_q <= ip_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acc_q <= `ACC_RESET;
    end else if (instr_valid) begin
      if (op == OP_ROM_TABLE_READ) begin
        acc_q <= rom_word[7:0];
      end else if (op == OP_RESTORE) begin
        acc_q <= acc_save_q;
      end else if (wr_res && !res_to_mem) begin
        acc_q <= res;
      end
    end
  end

  // save buffers written only by the save op
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acc_save_q <= `ACC_RESET;
      flags_save_q <= 8'h00;
    end else if (instr_valid && op == OP_SAVE) begin
      acc_save_q <= acc_q;
      flags_save_q <= status_view;
    end
  end

  // cause captured while reset is held
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cause_q <= reset_cause_in;
    end else if (instr_valid && op == OP_RESTORE) begin
      cause_q <= flags_save_q[`FLAG_CAUSE_HI:`FLAG_CAUSE_LO];
    end else if (instr_valid && wr_res && res_to_mem && dest_addr == `ADDR_STATUS) begin
      cause_q <= res[`FLAG_CAUSE_HI:`FLAG_CAUSE_LO];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flags_q <= `FLAGS_RESET;
    end else if (instr_valid) begin
      if (op == OP_RESTORE) begin
        flags_q <= flags_save_q[2:0];
      end else if (wr_res && res_to_mem && dest_addr == `ADDR_STATUS) begin
        flags_q <= res[2:0];
      end else begin
        flags_q <= flags_d;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      table_high_q <= `WORK_RESET;
      index_q <= `WORK_RESET;
      bank_q <= `WORK_RESET;
    end else if (instr_valid) begin
      if (op == OP_ROM_TABLE_READ) begin
        table_high_q <= rom_word[15:8];
      end else if (wr_res && res_to_mem && dest_addr == `ADDR_TABLE_HIGH) begin
        table_high_q <= res;
      end
      if (wr_res && res_to_mem && dest_addr == `ADDR_INDEX_PTR) begin
        index_q <= res;
      end
      if (wr_res && res_to_mem && dest_addr == `ADDR_BANK_PTR) begin
        bank_q <= res;
      end
    end
  end

  // results aimed elsewhere go out to data memory
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mem_we_q <= 1'b0;
      mem_addr_q <= 8'h00;
      mem_wdata_q <= 8'h00;
    end else begin
      mem_we_q <= instr_valid && wr_res && res_to_mem && dest_addr != `ADDR_TABLE_HIGH
        && dest_addr != `ADDR_INDEX_PTR && dest_addr != `ADDR_BANK_PTR && dest_addr != `ADDR_STATUS
        && dest_addr != `ADDR_IP_LOW && dest_addr != `ADDR_IP_HIGH;
      mem_addr_q <= dest_addr;
      mem_wdata_q <= res;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      skip_q <= 1'b0;
    end else begin
      skip_q <= instr_valid && skip_d && op != OP_JMP && op != OP_CALL;
    end
  end

  // readback; unmapped addresses and reserved bits read zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sreg_rdata_q <= 8'h00;
    end else begin
      case (sreg_raddr)
        `ADDR_TABLE_HIGH: sreg_rdata_q <= table_high_q;
        `ADDR_INDEX_PTR: sreg_rdata_q <= index_q;
        `ADDR_BANK_PTR: sreg_rdata_q <= bank_q;
        `ADDR_STATUS: sreg_rdata_q <= status_view & `STATUS_RW_MASK;
        `ADDR_IP_LOW: sreg_rdata_q <= ip_q[7:0];
        `ADDR_IP_HIGH: sreg_rdata_q <= {6'h00, ip_q[9:8]};
        default: sreg_rdata_q <= 8'h00;
      endcase
    end
  end

  assign prog_addr = ip_q;
  assign accumulator = acc_q;
  assign bank_ptr = bank_q;
  assign index_ptr = index_q;
  assign sreg_rdata = sreg_rdata_q;
  assign mem_we = mem_we_q;
  assign mem_addr = mem_addr_q;
  assign mem_wdata = mem_wdata_q;
  assign skip_taken = skip_q;

endmodule

/* File: src/core_regs_cfg.svh */
`ifndef CORE_REGS_CFG_SVH
`define CORE_REGS_CFG_SVH

// system register addresses in bank 0
`define ADDR_TABLE_HIGH 8'h82
`define ADDR_INDEX_PTR 8'h83
`define ADDR_BANK_PTR 8'h84
`define ADDR_STATUS 8'h86
`define ADDR_IP_LOW 8'hce
`define ADDR_IP_HIGH 8'hcf

// status flag field positions
`define FLAG_ZERO 0
`define FLAG_NIBBLE 1
`define FLAG_CARRY 2
`define FLAG_CAUSE_LO 6
`define FLAG_CAUSE_HI 7
`define STATUS_RW_MASK 8'hc7

// reset-cause codes
`define CAUSE_WATCHDOG 2'b00
`define CAUSE_RESERVED 2'b01
`define CAUSE_LOW_VOLT 2'b10
`define CAUSE_EXT_PIN 2'b11

// widths and reset values
`define IP_WIDTH 10
`define IP_RESET 10'h000
`define FLAGS_RESET 3'b000
`define ACC_RESET 8'h00
`define WORK_RESET 8'h00
`define SKIP_STEP 10'h002
`define STEP_ONE 10'h001

`endif

/* File: src/core_regs_pkg.sv */
package core_regs_pkg;

  typedef enum logic [4:0] {
    OP_NOP,
    OP_MOV,
    OP_MOVI,
    OP_ADD,
    OP_ADC,
    OP_SUB,
    OP_SBC,
    OP_AND,
    OP_OR,
    OP_XOR,
    OP_RLC,
    OP_RRC,
    OP_COMPARE_SKIP_EQ,
    OP_INC_SKIP_TO_ACCUM,
    OP_INC_SKIP_TO_MEM,
    OP_DEC_SKIP_TO_ACCUM,
    OP_DEC_SKIP_TO_MEM,
    OP_BIT_TEST_SKIP_CLEAR,
    OP_BIT_TEST_SKIP_SET,
    OP_JMP,
    OP_CALL,
    OP_SAVE,
    OP_RESTORE,
    OP_ROM_TABLE_READ
  } op_t;

endpackage

/* File: verification/data_mem.sv */
`timescale 1ns/1ns
module data_mem (
  input wire logic sys_clk,
  input wire logic mem_we,
  input wire logic [7:0] mem_addr,
  input wire logic [7:0] mem_wdata
);
  logic [7:0] cells [256];
  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      cells[mem_addr] <= mem_wdata;
    end
  end
endmodule

/* File: verification/core_regs_chk.sv */
`timescale 1ns/1ns
module core_regs_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire core_regs_pkg::op_t op,
  input wire logic [7:0] operand,
  input wire logic [2:0] bit_sel,
  input wire logic [9:0] jump_target,
  input wire logic [15:0] rom_word,
  input wire logic [9:0] prog_addr,
  input wire logic [7:0] accumulator,
  input wire logic skip_taken
);
  import core_regs_pkg::*;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  ip_step_a: assert property (
    instr_valid && op == OP_NOP |=> prog_addr == $past(prog_addr) + 10'h001)
    else $error("pc step wrong");
  idle_hold_a: assert property (
    !instr_valid |=> $stable(prog_addr) && $stable(accumulator))
    else $error("state moved while idle");
  jump_load_a: assert property (
    instr_valid && (op == OP_JMP || op == OP_CALL) |=> prog_addr == $past(jump_target))
    else $error("jump target not loaded");
  cmp_skip_a: assert property (
    instr_valid && op == OP_COMPARE_SKIP_EQ && operand == accumulator
    |=> skip_taken && prog_addr == $past(prog_addr) + 10'h002)
    else $error("compare skip wrong");
  skip_cause_a: assert property (
    skip_taken |-> $past(instr_valid))
    else $error("skip without instruction");
  inc_wrap_a: assert property (
    instr_valid && op == OP_INC_SKIP_TO_ACCUM && operand == 8'hff |=> skip_taken && accumulator == 8'h00)
    else $error("increment wrap wrong");
  dec_wrap_a: assert property (
    instr_valid && op == OP_DEC_SKIP_TO_ACCUM && operand == 8'h00 |=> skip_taken && accumulator == 8'hff)
    else $error("decrement wrap wrong");
  table_low_a: assert property (
    instr_valid && op == OP_ROM_TABLE_READ |=> accumulator == $past(rom_word[7:0]))
    else $error("table low byte wrong");
  bit_skip_a: assert property (
    instr_valid && ((op == OP_BIT_TEST_SKIP_SET && operand[bit_sel])
    || (op == OP_BIT_TEST_SKIP_CLEAR && !operand[bit_sel])) |=> skip_taken)
    else $error("bit test skip wrong");
endmodule
bind core_working_regs core_regs_chk core_regs_chk_i (.sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid),
  .op(op), .operand(operand), .bit_sel(bit_sel), .jump_target(jump_target), .rom_word(rom_word),
  .prog_addr(prog_addr), .accumulator(accumulator), .skip_taken(skip_taken));

/* File: verification/tb.sv */
`timescale 1ns/1ns
module tb;
  import core_regs_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, instr_valid = 1'b0, to_mem = 1'b0;
  op_t op = OP_NOP;
  logic [7:0] operand = 8'h00, dest_addr = 8'h00, sreg_raddr = 8'h00;
  logic [2:0] bit_sel = 3'h0;
  logic [9:0] jump_target = 10'h000, prog_addr;
  logic [15:0] rom_word = 16'h0000;
  logic [1:0] reset_cause_in = 2'h3;
  logic [7:0] accumulator, bank_ptr, index_ptr, sreg_rdata, mem_addr, mem_wdata;
  logic mem_we, skip_taken;
  int fail_count = 0, n_checks = 0;
  core_working_regs core_working_regs_i (.sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid), .op(op),
    .to_mem(to_mem), .operand(operand), .dest_addr(dest_addr), .bit_sel(bit_sel), .jump_target(jump_target),
    .rom_word(rom_word), .reset_cause_in(reset_cause_in), .sreg_raddr(sreg_raddr), .prog_addr(prog_addr),
    .accumulator(accumulator), .bank_ptr(bank_ptr), .index_ptr(index_ptr), .sreg_rdata(sreg_rdata),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .skip_taken(skip_taken));
  data_mem data_mem_i (.sys_clk(sys_clk), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata));
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic cmp(logic [23:0] g, logic [23:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic done(string s);
    $display("test %s done", s);
  endtask
  // one instruction, result settled on return
  task automatic ex(op_t o, logic [7:0] v = 8'h00, logic tm = 1'b0, logic [7:0] d = 8'h00,
                    logic [2:0] b = 3'h0, logic [9:0] j = 10'h000, logic [15:0] w = 16'h0000);
    @(posedge sys_clk);
    op <= o;
    operand <= v;
    to_mem <= tm;
    dest_addr <= d;
    bit_sel <= b;
    jump_target <= j;
    rom_word <= w;
    instr_valid <= 1'b1;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge sys_clk);
    sreg_raddr <= a;
    @(posedge sys_clk);
    #1;
    cmp(sreg_rdata, e);
  endtask
  task automatic rs(logic [1:0] c);
    @(posedge sys_clk);
    rst <= 1'b1;
    reset_cause_in <= c;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
  endtask
  initial begin
    repeat (4000) @(posedge sys_clk);
    fail_count++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      rs(c[1:0]);
      rd(8'h86, {c[1:0], 6'h00});
      cmp(prog_addr, 10'h000);
    end
    done("reset");
    ex(OP_NOP);
    cmp(prog_addr, 10'h001);
    ex(OP_MOV, 8'h12);
    ex(OP_COMPARE_SKIP_EQ, 8'h12);
    cmp({prog_addr, skip_taken}, {10'h004, 1'b1});
    rd(8'h86, 8'hc5);
    ex(OP_COMPARE_SKIP_EQ, 8'h13);
    cmp({prog_addr, skip_taken}, {10'h005, 1'b0});
    rd(8'h86, 8'hc0);
    done("compare");
    ex(OP_INC_SKIP_TO_ACCUM, 8'hff);
    cmp({prog_addr, accumulator}, {10'h007, 8'h00});
    ex(OP_DEC_SKIP_TO_ACCUM, 8'h00);
    cmp({prog_addr, accumulator}, {10'h009, 8'hff});
    ex(OP_INC_SKIP_TO_MEM, 8'hff, 1'b1, 8'h20);
    cmp({prog_addr, accumulator}, {10'h00b, 8'hff});
    ex(OP_DEC_SKIP_TO_MEM, 8'h05, 1'b1, 8'h21);
    cmp({prog_addr, data_mem_i.cells[8'h20]}, {10'h00c, 8'h00});
    ex(OP_BIT_TEST_SKIP_CLEAR, 8'h04, 1'b0, 8'h00, 3'h2);
    cmp({prog_addr, skip_taken}, {10'h00d, 1'b0});
    ex(OP_BIT_TEST_SKIP_SET, 8'h04, 1'b0, 8'h00, 3'h2);
    cmp({prog_addr, skip_taken, data_mem_i.cells[8'h21]}, {10'h00f, 1'b1, 8'h04});
    done("skips");
    ex(OP_JMP, 8'h00, 1'b0, 8'h00, 3'h0, 10'h2f0);
    cmp(prog_addr, 10'h2f0);
    ex(OP_CALL, 8'h00, 1'b0, 8'h00, 3'h0, 10'h1f0);
    cmp(prog_addr, 10'h1f0);
    ex(OP_MOV, 8'h20);
    ex(OP_ADD, 8'hf1, 1'b1, 8'hce);
    cmp(prog_addr, 10'h211);
    ex(OP_SUB, 8'h11, 1'b1, 8'hce);
    cmp(prog_addr, 10'h2f1);
    ex(OP_MOV, 8'h28);
    ex(OP_MOV, 8'h28, 1'b1, 8'hce);
    cmp(prog_addr, 10'h228);
    done("pointer");
    ex(OP_MOV, 8'h33);
    ex(OP_MOV, 8'h33, 1'b1, 8'h84);
    ex(OP_MOV, 8'h33, 1'b1, 8'h83);
    cmp({bank_ptr, index_ptr}, 16'h3333);
    rd(8'h84, 8'h33);
    rd(8'h85, 8'h00);
    ex(OP_ROM_TABLE_READ, 8'h00, 1'b0, 8'h00, 3'h0, 10'h000, 16'hab12);
    cmp(accumulator, 8'h12);
    rd(8'h82, 8'hab);
    ex(OP_SAVE);
    ex(OP_MOV, 8'h00);
    ex(OP_RESTORE);
    cmp(accumulator, 8'h12);
    done("registers");
    ex(OP_MOV, 8'h0f);
    ex(OP_ADD, 8'h01);
    cmp(accumulator, 8'h10);
    rd(8'h86, 8'hc2);
    ex(OP_ADD, 8'hf0);
    rd(8'h86, 8'hc5);
    cmp({prog_addr, accumulator}, {10'h232, 8'h00});
    ex(OP_MOVI, 8'h5a, 1'b0, 8'h82);
    rd(8'h82, 8'h5a);
    ex(OP_MOVI, 8'h01, 1'b0, 8'hcf);
    cmp(prog_addr, 10'h134);
    rd(8'hcf, 8'h01);
    rd(8'hce, 8'h34);
    done("flags");
    summarize();
  end
endmodule
